// ===== include/lts_pkg.sv
package lts_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses on the APB)
  // ------------------------------------------------------------
  localparam logic [7:0] LTS_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] LTS_ADDR_REQ    = 8'h04;
  localparam logic [7:0] LTS_ADDR_LIMIT  = 8'h08;
  localparam logic [7:0] LTS_ADDR_LINK   = 8'h0C;
  localparam logic [7:0] LTS_ADDR_STATUS = 8'h10;
  localparam logic [7:0] LTS_ADDR_TR     = 8'h14;
  localparam logic [7:0] LTS_ADDR_LTR    = 8'h18;
  localparam logic [7:0] LTS_ADDR_PTB    = 8'h1C;
  localparam logic [7:0] LTS_ADDR_RESUME = 8'h20;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  // CTRL
  localparam int LTS_CTRL_START    = 0;
  localparam int LTS_CTRL_CLR_TS   = 1;
  localparam int LTS_CTRL_LONG     = 2;
  // REQ
  localparam int LTS_REQ_KIND_LSB  = 0;
  localparam int LTS_REQ_GATE      = 3;
  localparam int LTS_REQ_CPL_LSB   = 4;
  localparam int LTS_REQ_RPL_LSB   = 6;
  localparam int LTS_REQ_GDPL_LSB  = 8;
  localparam int LTS_REQ_DDPL_LSB  = 10;
  localparam int LTS_REQ_TBL_LSB   = 12;
  localparam int LTS_REQ_BUSY      = 14;
  localparam int LTS_REQ_NT        = 15;
  localparam int LTS_REQ_SEL_LSB   = 16;
  // STATUS
  localparam int LTS_ST_ACTIVE     = 0;
  localparam int LTS_ST_DONE       = 1;
  localparam int LTS_ST_GP         = 2;
  localparam int LTS_ST_TS         = 3;
  localparam int LTS_ST_TSBIT      = 4;
  localparam int LTS_ST_NT         = 5;
  localparam int LTS_ST_NOSWITCH   = 6;
  localparam int LTS_ST_PRESENT    = 8;
  // Busy-update word towards memory
  localparam int LTS_BW_CLR_OLD    = 0;
  localparam int LTS_BW_SET_NEW    = 1;
  localparam int LTS_BW_LINK       = 2;
  localparam int LTS_BW_SEL_LSB    = 16;
  // Save word towards memory
  localparam int LTS_SW_NT         = 0;
  // Load word from memory
  localparam int LTS_LW_NT         = 16;
  // Busy flag position in the descriptor word at byte +4
  localparam int LTS_DESC_BUSY_BIT = 9;
  localparam logic [2:0] LTS_DESC_BUSY_BYTE = 3'h4;

  // ------------------------------------------------------------
  // Values
  // ------------------------------------------------------------
  localparam logic [19:0] LTS_MIN_LIMIT  = 20'h0_0067;
  localparam logic [1:0]  LTS_TBL_GDT    = 2'h0;
  localparam logic [1:0]  LTS_TBL_LDT    = 2'h1;
  localparam logic [1:0]  LTS_TBL_IDT    = 2'h2;
  localparam int          LTS_NSEG       = 6;
  localparam logic [31:0] LTS_RST_PTB    = 32'h0000_0000;
  localparam logic [15:0] LTS_RST_SEL    = 16'h0000;

  // Trigger kinds
  typedef enum logic [2:0] {
    LTS_K_JMP  = 3'h0,
    LTS_K_CALL = 3'h1,
    LTS_K_SOFTWARE_INTERRUPT = 3'h2,
    LTS_K_EXT  = 3'h3,
    LTS_K_INTERRUPT_RETURN = 3'h4,
    LTS_K_RET  = 3'h5
  } lts_kind_t;

  // Memory operations of the sequence
  typedef enum logic [2:0] {
    LTS_OP_NONE = 3'h0,
    LTS_OP_SAVE = 3'h1,
    LTS_OP_BUSY = 3'h2,
    LTS_OP_LOAD = 3'h3,
    LTS_OP_LDT  = 3'h4,
    LTS_OP_PTB  = 3'h5,
    LTS_OP_DESC = 3'h6
  } lts_op_t;

  // Sequencer states, one-hot
  typedef enum logic [10:0] {
    LTS_S_IDLE  = 11'b000_0000_0001,
    LTS_S_CHECK = 11'b000_0000_0010,
    LTS_S_SAVE  = 11'b000_0000_0100,
    LTS_S_TR    = 11'b000_0000_1000,
    LTS_S_BUSY  = 11'b000_0001_0000,
    LTS_S_TSB   = 11'b000_0010_0000,
    LTS_S_LOAD  = 11'b000_0100_0000,
    LTS_S_LDT   = 11'b000_1000_0000,
    LTS_S_PTB   = 11'b001_0000_0000,
    LTS_S_DESC  = 11'b010_0000_0000,
    LTS_S_DONE  = 11'b100_0000_0000
  } lts_state_t;

  // Request to descriptor/segment memory
  typedef struct packed {
    logic        valid;
    lts_op_t     op;
    logic [15:0] sel;
    logic [31:0] wdata;
  } lts_mem_req_t;

  // Answer from descriptor/segment memory
  typedef struct packed {
    logic        ack;
    logic        fault;
    logic [31:0] rdata;
  } lts_mem_rsp_t;

endpackage

// ===== rtl/lts_task_switch.sv
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module lts_task_switch
  import lts_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output lts_mem_req_t      mem_req,
  input  wire lts_mem_rsp_t mem_rsp,
  input  wire logic         media_insn,
  output logic              nm_fault,
  output logic              switch_done,
  output logic              gp_fault,
  output logic              ts_fault
);

  // ----------------------------------------------------------
  // State record
  // ----------------------------------------------------------
  typedef struct packed {
    lts_state_t                  fsm;
    logic                        long_mode;
    logic [31:0]                 req;
    logic [19:0]                 limit;
    logic [15:0]                 link;
    logic [15:0]                 target;
    logic [15:0]                 tr;
    logic [19:0]                 tr_limit;
    logic [15:0]                 ltr;
    logic [31:0]                 ptb;
    logic                        ts_bit;
    logic                        nt;
    logic [LTS_NSEG-1:0]         present;
    logic                        done;
    logic                        gp;
    logic                        tsf;
    logic                        noswitch;
    logic                        pend_ts;
    logic [15:0]                 new_cs;
    logic [31:0]                 wdata;
    logic                        nm;
    logic                        done_p;
    logic                        gp_p;
    logic                        ts_p;
    logic [31:0]                 rdata;
  } lts_regs_t;

  lts_regs_t r;
  lts_regs_t next_r;

  // ----------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------
  lts_kind_t   kind;
  logic        via_gate;
  logic [1:0]  current_privilege_level;
  logic [1:0]  requested_privilege_level;
  logic [1:0]  gdpl;
  logic [1:0]  ddpl;
  logic [1:0]  tbl;
  logic        tgt_busy;
  logic        nest_kind;
  logic        src_ok;
  logic        priv_ok;
  logic        do_switch;

  assign kind     = lts_kind_t'(r.req[LTS_REQ_KIND_LSB +: 3]);
  assign via_gate = r.req[LTS_REQ_GATE];
  assign current_privilege_level      = r.req[LTS_REQ_CPL_LSB +: 2];
  assign requested_privilege_level      = r.req[LTS_REQ_RPL_LSB +: 2];
  assign gdpl     = r.req[LTS_REQ_GDPL_LSB +: 2];
  assign ddpl     = r.req[LTS_REQ_DDPL_LSB +: 2];
  assign tbl      = r.req[LTS_REQ_TBL_LSB +: 2];
  assign tgt_busy = r.req[LTS_REQ_BUSY];

  // Kinds that build a nesting chain
  assign nest_kind = (kind == LTS_K_CALL) || (kind == LTS_K_SOFTWARE_INTERRUPT) || (kind == LTS_K_EXT);

  // Accepted sources of a switch; anything else is a protection fault
  always_comb
  begin
    src_ok    = 1'b0;
    do_switch = 1'b1;
    case (kind)
      LTS_K_JMP, LTS_K_CALL:
      begin
        // gate in local/global, descriptor global only
        src_ok = via_gate ? ((tbl == LTS_TBL_GDT) || (tbl == LTS_TBL_LDT))
                          : (tbl == LTS_TBL_GDT);
      end
      LTS_K_SOFTWARE_INTERRUPT, LTS_K_EXT:
      begin
        src_ok = via_gate && (tbl == LTS_TBL_IDT);
      end
      LTS_K_INTERRUPT_RETURN:
      begin
        src_ok    = 1'b1;
        do_switch = r.req[LTS_REQ_NT];
      end
      default:
      begin
        src_ok    = 1'b1;
        do_switch = 1'b0;
      end
    endcase
  end

  // Privilege checks depend on how the switch began
  always_comb
  begin
    priv_ok = 1'b1;
    if ((kind == LTS_K_JMP) || (kind == LTS_K_CALL))
    begin
      if (via_gate)
      begin
        // gate level only, target level ignored
        priv_ok = (current_privilege_level <= gdpl) && (requested_privilege_level <= gdpl);
      end
      else
      begin
        priv_ok = (current_privilege_level <= ddpl) && (requested_privilege_level <= ddpl);
      end
    end
  end

  // ----------------------------------------------------------
  // APB access decode
  // ----------------------------------------------------------
  logic wr_acc;
  logic rd_acc;
  logic mapped;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= LTS_ADDR_RESUME);

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------
  always_comb
  begin
    next_r        = r;
    next_r.nm     = 1'b0;
    next_r.done_p = 1'b0;
    next_r.gp_p   = 1'b0;
    next_r.ts_p   = 1'b0;

    // Software side: control and request loading
    if (wr_acc && mapped)
    begin
      case (paddr)
        LTS_ADDR_CTRL:
        begin
          next_r.long_mode = pwdata[LTS_CTRL_LONG];
          if (pwdata[LTS_CTRL_CLR_TS])
          begin
            next_r.ts_bit = 1'b0;
          end
          // A start while a switch runs is ignored
          if (pwdata[LTS_CTRL_START] && (r.fsm == LTS_S_IDLE))
          begin
            next_r.fsm      = LTS_S_CHECK;
            next_r.done     = 1'b0;
            next_r.gp       = 1'b0;
            next_r.tsf      = 1'b0;
            next_r.noswitch = 1'b0;
            next_r.pend_ts  = 1'b0;
          end
        end
        LTS_ADDR_REQ:
        begin
          if (r.fsm == LTS_S_IDLE)
          begin
            next_r.req = pwdata;
          end
        end
        LTS_ADDR_LIMIT:
        begin
          if (r.fsm == LTS_S_IDLE)
          begin
            next_r.limit = pwdata[19:0];
          end
        end
        LTS_ADDR_LINK:
        begin
          if (r.fsm == LTS_S_IDLE)
          begin
            next_r.link = pwdata[15:0];
          end
        end
        default:
        begin
          next_r.limit = next_r.limit;
        end
      endcase
    end

    // media instruction while bit set faults
    next_r.nm = media_insn && r.ts_bit;

    // one step at a time, fixed order
    case (r.fsm)
      LTS_S_IDLE:
      begin
        next_r.fsm = next_r.fsm;
      end
      LTS_S_CHECK:
      begin
        // return target comes from link field
        next_r.target = (kind == LTS_K_INTERRUPT_RETURN) ? r.link : r.req[LTS_REQ_SEL_LSB +: 16];
        // outgoing nested flag cleared on return
        next_r.wdata  = 32'h0000_0000;
        next_r.wdata[LTS_SW_NT] = (kind == LTS_K_INTERRUPT_RETURN) ? 1'b0 : r.nt;
        if (!do_switch)
        begin
          next_r.noswitch = 1'b1;
          next_r.fsm      = LTS_S_DONE;
        end
        // task gate refused in long mode
        else if (r.long_mode && via_gate)
        begin
          next_r.gp  = 1'b1;
          next_r.fsm = LTS_S_DONE;
        end
        else if (!src_ok || !priv_ok)
        begin
          next_r.gp  = 1'b1;
          next_r.fsm = LTS_S_DONE;
        end
        else if (r.limit < LTS_MIN_LIMIT)
        begin
          next_r.tsf = 1'b1;
          next_r.fsm = LTS_S_DONE;
        end
        // busy target refused on every kind but interrupt return
        else if ((kind != LTS_K_INTERRUPT_RETURN) && tgt_busy)
        begin
          next_r.gp  = 1'b1;
          next_r.fsm = LTS_S_DONE;
        end
        else
        begin
          next_r.fsm = LTS_S_SAVE;
        end
      end
      LTS_S_SAVE:
      begin
        // outgoing state stored by memory op
        if (mem_rsp.ack)
        begin
          // a fault here still aborts cleanly
          if (mem_rsp.fault)
          begin
            next_r.tsf = 1'b1;
            next_r.fsm = LTS_S_DONE;
          end
          else
          begin
            next_r.fsm = LTS_S_TR;
          end
        end
      end
      LTS_S_TR:
      begin
        // task register and its hidden part
        next_r.tr       = r.target;
        next_r.tr_limit = r.limit;
        next_r.wdata    = 32'h0000_0000;
        next_r.wdata[LTS_BW_SEL_LSB +: 16] = r.tr;
        // jump clears old busy, sets new
        // nesting keeps old busy, sets new
        next_r.wdata[LTS_BW_CLR_OLD] = (kind == LTS_K_JMP) || (kind == LTS_K_INTERRUPT_RETURN);
        next_r.wdata[LTS_BW_SET_NEW] = (kind != LTS_K_INTERRUPT_RETURN);
        next_r.wdata[LTS_BW_LINK]    = nest_kind;
        next_r.fsm = LTS_S_BUSY;
      end
      LTS_S_BUSY:
      begin
        if (mem_rsp.ack)
        begin
          next_r.pend_ts = r.pend_ts || mem_rsp.fault;
          next_r.fsm     = LTS_S_TSB;
        end
      end
      LTS_S_TSB:
      begin
        next_r.ts_bit = 1'b1;
        next_r.fsm    = LTS_S_LOAD;
      end
      LTS_S_LOAD:
      begin
        next_r.present = '0;
        if (mem_rsp.ack)
        begin
          next_r.pend_ts = r.pend_ts || mem_rsp.fault;
          next_r.new_cs  = mem_rsp.rdata[15:0];
          // jump keeps the loaded flag as stored
          next_r.nt      = nest_kind ? 1'b1 : mem_rsp.rdata[LTS_LW_NT];
          next_r.fsm     = LTS_S_LDT;
        end
      end
      LTS_S_LDT:
      begin
        if (mem_rsp.ack)
        begin
          next_r.ltr     = mem_rsp.rdata[15:0];
          next_r.pend_ts = r.pend_ts || mem_rsp.fault;
          next_r.fsm     = LTS_S_PTB;
        end
      end
      LTS_S_PTB:
      begin
        if (mem_rsp.ack)
        begin
          next_r.ptb     = mem_rsp.rdata;
          next_r.pend_ts = r.pend_ts || mem_rsp.fault;
          next_r.fsm     = LTS_S_DESC;
        end
      end
      LTS_S_DESC:
      begin
        if (mem_rsp.ack)
        begin
          next_r.present = mem_rsp.rdata[LTS_NSEG-1:0];
          next_r.pend_ts = r.pend_ts || mem_rsp.fault;
          next_r.fsm     = LTS_S_DONE;
        end
      end
      LTS_S_DONE:
      begin
        // task fault raised after the load
        next_r.tsf    = r.tsf || r.pend_ts;
        next_r.done   = 1'b1;
        next_r.done_p = !r.gp && !r.tsf && !r.pend_ts && !r.noswitch;
        next_r.gp_p   = r.gp;
        next_r.ts_p   = r.tsf || r.pend_ts;
        next_r.fsm    = LTS_S_IDLE;
      end
      default:
      begin
        next_r.fsm = LTS_S_IDLE;
      end
    endcase

    // Read data is registered during the setup phase
    next_r.rdata = 32'h0000_0000;
    if (rd_acc && !penable)
    begin
      case (paddr)
        LTS_ADDR_CTRL:
        begin
          next_r.rdata[LTS_CTRL_LONG] = r.long_mode;
        end
        LTS_ADDR_REQ:    next_r.rdata = r.req;
        LTS_ADDR_LIMIT:  next_r.rdata = {12'h000, r.limit};
        LTS_ADDR_LINK:   next_r.rdata = {16'h0000, r.link};
        LTS_ADDR_STATUS:
        begin
          next_r.rdata[LTS_ST_ACTIVE]   = (r.fsm != LTS_S_IDLE);
          next_r.rdata[LTS_ST_DONE]     = r.done;
          next_r.rdata[LTS_ST_GP]       = r.gp;
          next_r.rdata[LTS_ST_TS]       = r.tsf;
          next_r.rdata[LTS_ST_TSBIT]    = r.ts_bit;
          next_r.rdata[LTS_ST_NT]       = r.nt;
          next_r.rdata[LTS_ST_NOSWITCH] = r.noswitch;
          next_r.rdata[LTS_ST_PRESENT +: LTS_NSEG] = r.present;
        end
        LTS_ADDR_TR:     next_r.rdata = {r.tr_limit[15:0], r.tr};
        LTS_ADDR_LTR:    next_r.rdata = {16'h0000, r.ltr};
        LTS_ADDR_PTB:    next_r.rdata = r.ptb;
        LTS_ADDR_RESUME: next_r.rdata = {14'h0000, r.new_cs[1:0], r.new_cs};
        default:         next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r          <= '0;
      r.fsm      <= LTS_S_IDLE;
      r.tr       <= LTS_RST_SEL;
      r.ltr      <= LTS_RST_SEL;
      r.ptb      <= LTS_RST_PTB;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------
  // Memory request, held steady while its step waits for ack
  // ----------------------------------------------------------
  always_comb
  begin
    mem_req       = '0;
    mem_req.sel   = r.target;
    mem_req.wdata = r.wdata;
    case (r.fsm)
      LTS_S_SAVE:
      begin
        mem_req.valid = 1'b1;
        mem_req.op    = LTS_OP_SAVE;
        mem_req.sel   = r.tr;
      end
      LTS_S_BUSY:
      begin
        mem_req.valid = 1'b1;
        mem_req.op    = LTS_OP_BUSY;
      end
      LTS_S_LOAD:
      begin
        mem_req.valid = 1'b1;
        mem_req.op    = LTS_OP_LOAD;
      end
      LTS_S_LDT:
      begin
        mem_req.valid = 1'b1;
        mem_req.op    = LTS_OP_LDT;
      end
      LTS_S_PTB:
      begin
        mem_req.valid = 1'b1;
        mem_req.op    = LTS_OP_PTB;
      end
      LTS_S_DESC:
      begin
        mem_req.valid = 1'b1;
        mem_req.op    = LTS_OP_DESC;
      end
      default:
      begin
        mem_req.valid = 1'b0;
      end
    endcase
  end

  // Outputs straight from flops
  assign prdata      = r.rdata;
  assign nm_fault    = r.nm;
  assign switch_done = r.done_p;
  assign gp_fault    = r.gp_p;
  assign ts_fault    = r.ts_p;

endmodule

`default_nettype wire

// ===== verification/lts_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module lts_mem_model
  import lts_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire lts_mem_req_t mem_req,
  output lts_mem_rsp_t     mem_rsp,
  input wire logic [1:0]   lat,
  input wire lts_op_t      bad_op,
  output logic [31:0]      save_word,
  output logic [31:0]      busy_word
);
  logic [1:0]  wait_cnt;
  logic [31:0] word;

  always_comb
    case (mem_req.op)
      LTS_OP_LOAD: word = 32'h0000_001B;
      LTS_OP_LDT:  word = 32'h0000_0028;
      LTS_OP_PTB:  word = 32'h0012_3000;
      LTS_OP_DESC: word = 32'h0000_002D;
      default:     word = 32'h0000_0000;
    endcase

  // Idle data shows the inverse, so a stale read cannot pass
  always_comb
  begin
    mem_rsp.ack = mem_req.valid && wait_cnt == lat;
    mem_rsp.fault = mem_rsp.ack && mem_req.op == bad_op;
    mem_rsp.rdata = mem_rsp.ack ? word : ~word;
  end

  // saved state and busy update kept for the bench
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wait_cnt <= 2'h0;
      save_word <= 32'h0000_0000;
      busy_word <= 32'h0000_0000;
    end
    else
    begin
      wait_cnt <= (mem_req.valid && !mem_rsp.ack) ? wait_cnt + 2'h1 : 2'h0;
      if (mem_rsp.ack && mem_req.op == LTS_OP_SAVE)
        save_word <= mem_req.wdata;
      if (mem_rsp.ack && mem_req.op == LTS_OP_BUSY)
        busy_word <= mem_req.wdata;
    end
endmodule

`default_nettype wire

// ===== verification/lts_task_switch_properties.sv
`timescale 1ns/1ps
`default_nettype none

module lts_checker
  import lts_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [7:0]   paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire lts_mem_req_t mem_req,
  input wire lts_mem_rsp_t mem_rsp,
  input wire logic         media_insn,
  input wire logic         nm_fault,
  input wire logic         switch_done,
  input wire logic         gp_fault,
  input wire logic         ts_fault
);
  // ----------
  // Helpers
  // ----------
  lts_op_t prev_op;
  logic    step;

  // A memory step is done when the partner acks it
  assign step = mem_req.valid && mem_rsp.ack;

  // Last finished step, cleared by a done, gp or ts pulse
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prev_op <= LTS_OP_NONE;
    else if (switch_done || gp_fault || ts_fault)
      prev_op <= LTS_OP_NONE;
    else if (step)
      prev_op <= mem_req.op;

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------
  // Assertions
  // ----------
  step_order_a: assert property (
    step |-> mem_req.op == lts_op_t'(prev_op + 3'h1)) else $error("memory step out of order");
  req_hold_a: assert property (
    mem_req.valid && !mem_rsp.ack |=> $stable(mem_req)) else $error("request moved before ack");
  done_excl_a: assert property (
    !(switch_done && (gp_fault || ts_fault))) else $error("done together with fault");
  nm_cause_a: assert property (
    nm_fault |-> $past(media_insn)) else $error("nm fault without media insn");
  gp_quiet_a: assert property (
    gp_fault |-> !$past(mem_req.valid) && !$past(mem_req.valid, 2)) else $error("gp after memory");
  done_tail_a: assert property (
    switch_done |-> $past(step, 2) && $past(mem_req.op, 2) == LTS_OP_DESC)
    else $error("done not two cycles after descriptor load");
  save_abort_a: assert property (
    step && mem_rsp.fault && mem_req.op == LTS_OP_SAVE |-> ##[1:3] ts_fault)
    else $error("save fault not reported");
  late_fault_a: assert property (
    step && mem_rsp.fault && mem_req.op != LTS_OP_SAVE |-> ##[1:40] ts_fault)
    else $error("late fault not reported");

  done_c: cover property (switch_done);
  gp_c: cover property (gp_fault);
  late_c: cover property (step && mem_rsp.fault && mem_req.op == LTS_OP_LDT);
endmodule

`default_nettype wire

// ===== verification/lts_task_switch_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module lts_task_switch_tb_top
  import lts_pkg::*;
;
  logic         pclk, presetn, psel, penable, pwrite, media_insn;
  logic         pready, pslverr, nm_fault, switch_done, gp_fault, ts_fault, err_seen;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd, save_word, busy_word;
  logic [15:0]  sel, cur_tr;
  logic         cur_nt;
  logic [1:0]   lat;
  lts_op_t      bad_op;
  lts_mem_req_t mem_req;
  lts_mem_rsp_t mem_rsp;
  int           errors, comparisons, cyc;

  lts_task_switch dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_rsp(mem_rsp), .media_insn(media_insn),
    .nm_fault(nm_fault), .switch_done(switch_done), .gp_fault(gp_fault), .ts_fault(ts_fault));

  lts_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_rsp(mem_rsp),
    .lat(lat), .bad_op(bad_op), .save_word(save_word), .busy_word(busy_word));

  // ----------
  // Helpers
  // ----------
  always #50 pclk = ~pclk;

  // Hang guard, far above the several hundred cycles needed
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      close_out;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One transfer; held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task close_out;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------
  // Scenarios
  // ----------
  task bus_chk;
    rdc(LTS_ADDR_TR, {16'h0000, LTS_RST_SEL});
    rdc(LTS_ADDR_PTB, LTS_RST_PTB);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk({31'h0, err_seen}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
  endtask

  // Runs one request; res 1 done, 2 gp, 3 ts, 0 nothing
  task one(input logic [15:0] lo, input logic [7:0] lim, input logic lng,
           input lts_op_t bad, input logic [1:0] res);
    logic [1:0]  got;
    logic [15:0] old;
    logic        nest;
    logic        ir;
    logic        old_nt;
    got = 2'h0;
    old = cur_tr;
    old_nt = cur_nt;
    ir = lo[2:0] == LTS_K_INTERRUPT_RETURN;
    nest = lo[2:0] inside {LTS_K_CALL, LTS_K_SOFTWARE_INTERRUPT, LTS_K_EXT};
    sel = sel + 16'h0008;
    bad_op <= bad;
    lat <= lat + 2'h1;
    apb(1'b1, LTS_ADDR_REQ, {sel, lo});
    apb(1'b1, LTS_ADDR_LIMIT, {24'h00_0000, lim});
    apb(1'b1, LTS_ADDR_LINK, 32'h0000_0030);
    apb(1'b1, LTS_ADDR_CTRL, {29'h0, lng, 2'h0});
    apb(1'b1, LTS_ADDR_CTRL, {29'h0, lng, 2'h1});
    for (int i = 0; i < 60 && got == 2'h0; i++)
    begin
      @(posedge pclk);
      got = switch_done ? 2'h1 : gp_fault ? 2'h2 : ts_fault ? 2'h3 : 2'h0;
    end
    chk({30'h0, got}, {30'h0, res});
    // Limit and save aborts leave the task register alone; late faults still switch
    if (res == 2'h1 || (res == 2'h3 && bad != LTS_OP_SAVE && bad != LTS_OP_NONE))
    begin
      cur_tr = ir ? 16'h0030 : sel;
      // Nesting kinds force the flag; others take the stored flag, 0 in the model
      cur_nt = nest;
    end
    apb(1'b0, LTS_ADDR_TR, 32'h0000_0000);
    chk({16'h0, rd[15:0]}, {16'h0, cur_tr});
    apb(1'b0, LTS_ADDR_STATUS, 32'h0000_0000);
    chk({27'h0, rd[6], rd[3:0]},
        {27'h0, res == 2'h0, res == 2'h3, res == 2'h2, 1'b1, 1'b0});
    if (res == 2'h1)
    begin
      chk({busy_word[31:16], 13'h0, busy_word[2:0]},
          {old, 13'h0, nest, !ir, ir || lo[2:0] == LTS_K_JMP});
      chk({31'h0, save_word[0]}, {31'h0, old_nt && !ir});
      chk({24'h0, rd[13:8], rd[5:4]}, {24'h0, 6'h2D, nest, 1'b1});
      rdc(LTS_ADDR_RESUME, 32'h0003_001B);
      rdc(LTS_ADDR_LTR, 32'h0000_0028);
      rdc(LTS_ADDR_PTB, 32'h0012_3000);
    end
  endtask

  task cases;
    one(16'h08A1, 8'h67, 1'b0, LTS_OP_NONE, 2'h1);
    one(16'h1000, 8'h67, 1'b0, LTS_OP_NONE, 2'h2);
    one(16'h93F8, 8'h67, 1'b0, LTS_OP_NONE, 2'h1);
    one(16'h0C29, 8'h67, 1'b0, LTS_OP_NONE, 2'h2);
    one(16'h0040, 8'h67, 1'b0, LTS_OP_NONE, 2'h2);
    one(16'h20FA, 8'h67, 1'b0, LTS_OP_NONE, 2'h1);
    one(16'h200B, 8'h67, 1'b0, LTS_OP_NONE, 2'h1);
    one(16'h0001, 8'h66, 1'b0, LTS_OP_NONE, 2'h3);
    one(16'h4000, 8'h67, 1'b0, LTS_OP_NONE, 2'h2);
    one(16'h4001, 8'h67, 1'b0, LTS_OP_NONE, 2'h2);
    one(16'hC034, 8'h67, 1'b0, LTS_OP_NONE, 2'h1);
    one(16'h0004, 8'h67, 1'b0, LTS_OP_NONE, 2'h0);
    one(16'h8005, 8'h67, 1'b0, LTS_OP_NONE, 2'h0);
    one(16'h0009, 8'h67, 1'b1, LTS_OP_NONE, 2'h2);
    one(16'h0001, 8'h67, 1'b0, LTS_OP_SAVE, 2'h3);
    one(16'h0001, 8'h67, 1'b0, LTS_OP_LDT, 2'h3);
  endtask

  // Media pulse, then the fault one cycle later or not at all
  task media(input logic exp);
    @(posedge pclk);
    media_insn <= 1'b1;
    @(posedge pclk);
    media_insn <= 1'b0;
    @(posedge pclk);
    chk({31'h0, nm_fault}, {31'h0, exp});
  endtask

  task nm_chk;
    media(1'b1);
    apb(1'b1, LTS_ADDR_CTRL, 32'h0000_0002);
    media(1'b0);
  endtask

  // Bench sequence
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    media_insn = 1'b0;
    lat = 2'h0;
    bad_op = LTS_OP_NONE;
    sel = 16'h0040;
    cur_tr = LTS_RST_SEL;
    cur_nt = 1'b0;
    errors = 0;
    comparisons = 0;
    cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    bus_chk;
    cases;
    nm_chk;
    close_out;
  end
endmodule

bind lts_task_switch lts_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_rsp(mem_rsp),
  .media_insn(media_insn), .nm_fault(nm_fault), .switch_done(switch_done),
  .gp_fault(gp_fault), .ts_fault(ts_fault));

`default_nettype wire
